// file: hdl/sspl_top.sv
/*
 start/sync pulse logic of a multichannel sampling converter.
 a start request on start_n_in (active low, may be asynchronous to the
 master clock) passes a two-flop synchroniser and a falling-edge
 detector; each falling edge launches one active-low sync pulse of
 PULSE_CYC master clocks on sync_n_out. a start held low gives a single
 pulse; the next one needs the input to have returned high first.
 latency: sync_n_out falls on the third master clock edge that samples
 start low, one edge later if the first sample goes metastable.
 the sync input sync_n_in is taken without a synchroniser; a falling
 edge on it restarts the sample phase: restart_out pulses for one clock,
 phase_out returns to zero and sample_tick_out is withheld that cycle.
 otherwise phase_out counts 0 to ODR_DIV-1 and sample_tick_out marks
 each wrap.
 assumes: sync_n_in is driven synchronously to clk_in, normally by the
 looped-back sync_n_out of this device or of a partner device; an
 unused start_n_in is tied high; rst_n_in may fall at any time and is
 released into the logic through two flops, so the block ignores both
 inputs for two clocks after release.
*/
`timescale 1ns/1ps
module sspl_top
	import sspl_pkg::*;
#(
	parameter int ODR_DIV = SSPL_ODR_DIV,
	parameter int PULSE_CYC = SSPL_SYNC_PULSE_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_n_in,
	input wire logic sync_n_in,
	output logic sync_n_out,
	output logic sample_tick_out,
	output logic restart_out,
	output logic [SSPL_CNT_W-1:0] phase_out
);
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic start_s;
	logic start_d_reg;
	logic start_fall;
	sspl_state_t state_reg;
	sspl_state_t state_next;
	logic [SSPL_CNT_W-1:0] pulse_cnt_reg;
	logic sync_d_reg;
	logic sync_fall;
	logic [SSPL_CNT_W-1:0] phase_reg;
	logic [SSPL_CNT_W-1:0] phase_next;
	logic pulse_done;
	logic phase_wrap;
	logic sync_n_next;
	logic restart_next;
	logic tick_next;

	localparam logic [SSPL_CNT_W-1:0] ODR_LAST =
		SSPL_CNT_W'(ODR_DIV - 1);
	localparam logic [SSPL_CNT_W-1:0] PULSE_LAST =
		SSPL_CNT_W'(PULSE_CYC - 1);

	// one incrementer for both counters keeps their widths in step
	function automatic logic [SSPL_CNT_W-1:0] cnt_inc(
		input logic [SSPL_CNT_W-1:0] value
	);
		return value + 16'h0001;
	endfunction

	function automatic logic cnt_at(
		input logic [SSPL_CNT_W-1:0] value,
		input logic [SSPL_CNT_W-1:0] last
	);
		return value == last;
	endfunction

	assign pulse_done = cnt_at(pulse_cnt_reg, PULSE_LAST);
	assign phase_wrap = cnt_at(phase_reg, ODR_LAST);

	// reset released through two flops; assertion stays asynchronous
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// start comes from another clock domain
	sspl_sync2 #(
		.RST_VAL(SSPL_START_IDLE)
	) u_start_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_sync_reg),
		.d_in(start_n_in),
		.q_out(start_s)
	);

	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			start_d_reg <= SSPL_START_IDLE;
		end else begin
			start_d_reg <= start_s;
		end
	end

	// a start held low is one request; idle-high input never fires
	assign start_fall = start_d_reg & ~start_s;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SSPL_ST_IDLE: begin
				if (start_fall) begin
					state_next = SSPL_ST_PULSE;
				end
			end
			SSPL_ST_PULSE: begin
				if (pulse_done) begin
					state_next = SSPL_ST_WAIT_REL;
				end
			end
			SSPL_ST_WAIT_REL: begin
				// wait for release so one long start gives one sync
				if (start_s) begin
					state_next = SSPL_ST_IDLE;
				end
			end
			default: begin
				state_next = SSPL_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			state_reg <= SSPL_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pulse_cnt_reg <= SSPL_CNT_RST;
		end else if (state_reg == SSPL_ST_PULSE) begin
			pulse_cnt_reg <= cnt_inc(pulse_cnt_reg);
		end else begin
			pulse_cnt_reg <= SSPL_CNT_RST;
		end
	end

	// decoded from the next state so the pin moves with the state
	assign sync_n_next = (state_next != SSPL_ST_PULSE);

	// output flop on the master clock; low only while pulsing
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			sync_n_out <= SSPL_SYNC_IDLE;
		end else begin
			sync_n_out <= sync_n_next;
		end
	end

	// sync input is already on the master clock, so no synchroniser
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			sync_d_reg <= SSPL_SYNC_IDLE;
		end else begin
			sync_d_reg <= sync_n_in;
		end
	end

	assign sync_fall = sync_d_reg & ~sync_n_in;

	// sample phase counter restarts on every sync edge
	always_comb begin
		if (sync_fall) begin
			phase_next = SSPL_CNT_RST;
		end else if (phase_wrap) begin
			phase_next = SSPL_CNT_RST;
		end else begin
			phase_next = cnt_inc(phase_reg);
		end
	end

	// restart beats a wrap in the same cycle, so no tick then
	always_comb begin
		restart_next = sync_fall;
		tick_next = ~sync_fall & phase_wrap;
	end

	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			phase_reg <= SSPL_CNT_RST;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// twin of the phase flop so the pin comes straight from a flop
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			phase_out <= SSPL_CNT_RST;
		end else begin
			phase_out <= phase_next;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			restart_out <= 1'b0;
		end else begin
			restart_out <= restart_next;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			sample_tick_out <= 1'b0;
		end else begin
			sample_tick_out <= tick_next;
		end
	end
endmodule // sspl_top

// file: hdl/sspl_pkg.sv
/*
 constants for the start/sync pulse logic of a multichannel sampling
 converter. assumes one master clock of 20 MHz drives all of the logic.
*/
// Summary of operation
// - The start input may be asynchronous, and the device copes with it without a common clock.
// - A start pulse is sampled and then answered by a pulse on the sync output.
// - The start pulse is resynchronised inside, so the sync output is synchronous to the master clock.
// - The sync output pulses only when the start input feature is used, and is quiet otherwise.
package sspl_pkg;
	localparam int SSPL_CLK_HZ = 20000000;
	// width of the emitted sync pulse in master clocks
	localparam int SSPL_SYNC_PULSE_CYC = 1;
	// default decimation length of one output sample, in master clocks
	localparam int SSPL_ODR_DIV = 32;
	localparam int SSPL_CNT_W = 16;
	localparam logic SSPL_START_IDLE = 1'b1;
	localparam logic SSPL_SYNC_IDLE = 1'b1;
	localparam logic [SSPL_CNT_W-1:0] SSPL_CNT_RST = 16'h0000;

	typedef enum logic [1:0] {
		SSPL_ST_IDLE = 2'b00,
		SSPL_ST_PULSE = 2'b01,
		SSPL_ST_WAIT_REL = 2'b10
	} sspl_state_t;
endpackage

// file: hdl/sspl_sync2.sv
/*
 two flip-flop level synchroniser with a constant reset value.
 assumes d_in may change at any time relative to clk_in.
*/
`timescale 1ns/1ps
module sspl_sync2 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic d_in,
	output logic q_out
);
	logic meta_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_reg <= RST_VAL;
			q_out <= RST_VAL;
		end else begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule // sspl_sync2

// file: tb/sspl_checker.sv
/* port checker for sspl_top, bound into every instance.
 assumes rst_n_in is the raw reset and one master clock. */
`timescale 1ns/1ps
module sspl_checker
	import sspl_pkg::*;
#(parameter int ODR_DIV = SSPL_ODR_DIV) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_n_in,
	input wire logic sync_n_in,
	input wire logic sync_n_out,
	input wire logic sample_tick_out,
	input wire logic restart_out,
	input wire logic [SSPL_CNT_W-1:0] phase_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// start seen low at one edge: pin low three edges on, four if metastable
	answer_time_a: assert property (
		$fell(start_n_in) |-> ##[3:4] !sync_n_out)
		else $error("sync pulse late");
	start_cause_a: assert property (
		$fell(sync_n_out) |-> !$past(start_n_in, 3))
		else $error("sync pulse without start");
	pulse_width_a: assert property (
		$fell(sync_n_out) |=> sync_n_out)
		else $error("sync pulse too long");
	quiet_out_a: assert property (
		start_n_in [*6] |-> sync_n_out)
		else $error("sync pulse while start idle");
	restart_now_a: assert property (
		$fell(sync_n_in) |=> restart_out && phase_out == 0)
		else $error("no restart on sync");
	phase_wrap_a: assert property (
		phase_out == ODR_DIV - 1 |=> phase_out == 0)
		else $error("phase did not wrap");
	cover property ($fell(sync_n_out));
	cover property (restart_out && sync_n_out);
	cover property (sample_tick_out);
endmodule // sspl_checker

bind sspl_top sspl_checker #(.ODR_DIV(ODR_DIV)) sspl_checker_i (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .start_n_in(start_n_in),
	.sync_n_in(sync_n_in), .sync_n_out(sync_n_out),
	.sample_tick_out(sample_tick_out), .restart_out(restart_out),
	.phase_out(phase_out));

// file: tb/sspl_host.sv
/* host model: start requests and a system sync pulse, with the
 device's sync output looped back. assumes the 50 ns master clock. */
`timescale 1ns/1ps
module sspl_host (
	input wire logic clk_in,
	input wire logic sync_n_in,
	output logic start_n_out,
	output logic sync_n_out
);
	logic sys_n_reg = 1'b1;
	initial start_n_out = 1'b1;
	// low-active join, so loopback and system pulse share one line
	assign sync_n_out = sync_n_in & sys_n_reg;
	task start(input int hold);
		@(posedge clk_in);
		#1 start_n_out = 1'b0;
		repeat (hold) @(posedge clk_in);
		#1 start_n_out = 1'b1;
	endtask
	task sys_pulse();
		@(posedge clk_in);
		#1 sys_n_reg = 1'b0;
		@(posedge clk_in);
		#1 sys_n_reg = 1'b1;
	endtask
endmodule // sspl_host

// file: tb/sspl_top_tb.sv
/* bench for sspl_top with the host model on the far side.
 assumes the checker file binds itself in. */
`timescale 1ns/1ps
module sspl_top_tb;
	import sspl_pkg::*;
	localparam int DIV = 8;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic st_n, sy_n, so_n, tick, rst_o;
	logic [SSPL_CNT_W-1:0] ph;
	int mismatches = 0;
	int tests_run = 0;
	always #25 clk_in = ~clk_in;
	sspl_host sspl_host_i (.clk_in(clk_in), .sync_n_in(so_n),
		.start_n_out(st_n), .sync_n_out(sy_n));
	sspl_top #(.ODR_DIV(DIV)) sspl_top_i (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .start_n_in(st_n), .sync_n_in(sy_n),
		.sync_n_out(so_n), .sample_tick_out(tick),
		.restart_out(rst_o), .phase_out(ph));
	task check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task step();
		@(posedge clk_in);
		#1;
	endtask
	task t_start(input int hold);
		int n;
		n = 0;
		fork
			sspl_host_i.start(hold);
		join_none
		while (so_n !== 1'b0 && n < 20) begin
			step();
			n++;
		end
		// one edge for the host to drive, three of latency, one of jitter
		check(n inside {4, 5}, "sync timing");
		step();
		check(so_n === 1'b1 && rst_o === 1'b1, "width or restart");
		check(ph === 16'h0000, "phase kept");
		repeat (hold + 4) begin
			step();
			check(so_n === 1'b1, "extra pulse");
		end
	endtask
	task t_idle();
		int ticks;
		ticks = 0;
		repeat (3 * DIV) begin
			step();
			if (tick === 1'b1) ticks++;
			check(so_n === 1'b1, "pulse unasked");
		end
		check(ticks == 3, "tick count");
	endtask
	task t_sys();
		fork
			sspl_host_i.sys_pulse();
		join_none
		repeat (2) @(posedge clk_in);
		#2;
		check(rst_o === 1'b1 && ph === 16'h0000, "no restart");
		check(so_n === 1'b1, "sync out moved");
	endtask
	task give_verdict();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		repeat (4) step();
		t_idle();
		t_start(2);
		t_start(2);
		t_start(20);
		t_sys();
		give_verdict();
	end
	initial begin
		#50000;
		mismatches++;
		give_verdict();
	end
endmodule // sspl_top_tb
